// ---- rtl/intc_pkg.sv ----
// Shared constants and types for the interrupt priority controller
package intc_pkg;
  localparam int NUM_PINS = 15;
  localparam int NUM_SRC  = 19;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;
  // Register word addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_SENSE  = 4'h1;
  localparam logic [3:0] ADDR_ENABLE = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_PRIO_L = 4'h4;
  localparam logic [3:0] ADDR_PRIO_H = 4'h5;
  localparam logic [3:0] ADDR_ROUTE  = 4'h6;
  localparam logic [3:0] ADDR_LASTV  = 4'h7;
  // Control register fields
  localparam int CTRL_NMI_EDGE_BIT = 3;
  localparam int CTRL_MODE_LSB     = 4;
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_2 = 2'h2;
  // Sense codes, rise bit above fall bit
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
  // Reset values
  localparam logic [1:0]  MODE_RST  = 2'h0;
  localparam logic        NMIE_RST  = 1'h0;
  localparam logic [29:0] SENSE_RST = 30'h0;
  localparam logic [14:0] EN_RST    = 15'h0;
  localparam logic [29:0] PRL_RST   = 30'h0;
  localparam logic [26:0] PRH_RST   = 27'h0;
  localparam logic [18:0] ROUTE_RST = 19'h0;
  // Vector numbers
  localparam logic [7:0] VEC_NMI  = 8'h07;
  localparam logic [7:0] VEC_PIN0 = 8'h40;
  localparam logic [7:0] VEC_WDT  = 8'h51;
  localparam logic [7:0] VEC_TMR  = 8'h6e;
  localparam logic [7:0] VEC_OSC  = 8'h72;
  localparam logic [7:0] VEC_DMA  = 8'h80;
  localparam logic [2:0] NMI_LEVEL = 3'h7;
  // Sources allowed to start a transfer
  localparam logic [18:0] XFER_ELIGIBLE = 19'h57fff;
  typedef struct packed {
    logic        instr_done;
    logic        mask_bit;
    logic [2:0]  mask_level;
  } core_state_t;
  typedef struct packed {
    logic        take;
    logic [7:0]  vector;
    logic [15:0] vaddr;
    logic [2:0]  mask_level;
    logic        set_mask_bit;
    logic        clear_trace;
  } core_accept_t;
  typedef struct packed {
    logic transfer_error_set;
    logic dma_error_flag_set;
    logic dma_transfer_enable_clear;
  } nmi_error_t;
endpackage

// ---- rtl/interrupt_priority_controller.sv ----
// Interrupt priority controller between request sources and the core
//
// Overview of operation
// - Sixteen external inputs: nonmaskable pin and pins 14..0, all wake standby
// - Nonmaskable request is top priority, always taken regardless of mode or mask
// - Edge-select bit picks rising or falling edge for the nonmaskable pin
// - Nonmaskable event sets transfer and dma errors, clears all dma enables
// - Two-bit sense per pin: 00 low, 01 fall, 10 rise, 11 both
// - Each pin has an enable bit and a programmed priority level
// - Each pin sets a status flag that software may clear to zero
// - Flag clears: write 0 after read 1, handling, or transfer with select 0
// - Pin detection gated by port input control, independent of output setting
// - Peripheral request reaches controller only while its enable is 1
// - Only eligible sources may start the transfer or dma controller
// - Default priority: lower vector number wins
// - Mode 2 ties on level resolve by default vector order
// - Vector offset is four times vector; nonmaskable 7, pin 0 is 64
// - Two control modes, 0 and 2, chosen by control register field
// - Mode 2 gives eight levels, masked against three-bit core mask level
// - Mode 0 with mask bit 1 accepts only nonmaskable; others stay pending
// - Only the single highest-priority request is presented; others pend
// - Mode 2 accepts only a level above the current mask level
// - Handling begins only after the current instruction completes
// - Mode 0 acceptance sets the core mask bit
// - Mode 2 clears trace, loads accepted level or 7 for nonmaskable
// - Accepted request yields vector number and vector address to the core
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_controller (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic [intc_pkg::ADDR_W-1:0] addr,
  input  wire logic [intc_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [intc_pkg::DATA_W-1:0] rdata,
  input  wire logic                       nmi_pin,
  input  wire logic [14:0]                external_request_pin,
  input  wire logic [14:0]                pin_input_enable,
  input  wire logic [3:0]                 periph_flag,
  input  wire logic [3:0]                 periph_enable,
  input  wire intc_pkg::core_state_t      core_state,
  output logic                            core_request,
  output intc_pkg::core_accept_t          core_accept,
  output intc_pkg::nmi_error_t            nmi_error,
  output logic      [18:0]                transfer_request,
  input  wire logic [14:0]                transfer_done,
  input  wire logic                       transfer_interrupt_select,
  output logic                            wake_request
);
  import intc_pkg::*;

  logic [1:0]  mode_reg;
  logic [1:0]  mode_next;
  logic        nmi_edge_sel_reg;
  logic        nmi_edge_sel_next;
  logic [29:0] sense_reg;
  logic [29:0] sense_next;
  logic [14:0] enable_reg;
  logic [14:0] enable_next;
  logic [14:0] status_reg;
  logic [14:0] status_next;
  logic [14:0] seen_one_reg;
  logic [14:0] seen_one_next;
  logic [29:0] prio_lo_reg;
  logic [29:0] prio_lo_next;
  logic [26:0] prio_hi_reg;
  logic [26:0] prio_hi_next;
  logic [18:0] route_reg;
  logic [18:0] route_next;
  logic [7:0]  last_vec_reg;
  logic [7:0]  last_vec_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  logic [14:0] pin_s1_reg;
  logic [14:0] pin_s2_reg;
  logic [14:0] pin_prev_reg;
  logic [2:0]  nmi_sync_reg;
  logic        nmi_pend_reg;
  logic        nmi_pend_next;

  core_accept_t accept_reg;
  core_accept_t accept_next;
  nmi_error_t   err_reg;
  nmi_error_t   err_next;
  logic         wake_reg;
  logic         wake_next;

  logic [14:0] pin_event;
  logic [14:0] pin_clear;
  logic        nmi_event;
  logic [56:0] prio_all;
  logic [18:0] src_req;
  logic [18:0] routed;
  logic [18:0] cand;
  logic        found;
  logic [4:0]  best_idx;
  logic [2:0]  best_lvl;
  logic        allowed;
  logic        take_nmi;
  logic        take_src;
  logic [7:0]  sel_vec;
  logic        wr_status;
  logic        rd_status;

  function automatic logic [7:0] src_vector(input logic [4:0] idx);
    logic [7:0] v;
    v = VEC_PIN0 + {3'h0, idx};
    case (idx)
      5'd15: v = VEC_WDT;
      5'd16: v = VEC_TMR;
      5'd17: v = VEC_OSC;
      5'd18: v = VEC_DMA;
      default: v = VEC_PIN0 + {3'h0, idx};
    endcase
    return v;
  endfunction

  // Pins idle high, so the stages reset high and no false edge follows reset
  // Synchronisers and detection history
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_s1_reg   <= 15'h7fff;
      pin_s2_reg   <= 15'h7fff;
      pin_prev_reg <= 15'h7fff;
      nmi_sync_reg <= 3'h0;
    end else begin
      pin_s1_reg   <= external_request_pin;
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
      nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_pin};
    end
  end

  // Edge select: 1 picks rising, 0 falling
  assign nmi_event = nmi_edge_sel_reg ?
    (nmi_sync_reg[1] & ~nmi_sync_reg[2]) :
    (~nmi_sync_reg[1] & nmi_sync_reg[2]);

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      case (sense_reg[2*i +: 2])
        SENSE_LOW:
          pin_event[i] = ~pin_s2_reg[i];
        SENSE_FALL:
          pin_event[i] = pin_prev_reg[i] & ~pin_s2_reg[i];
        SENSE_RISE:
          pin_event[i] = ~pin_prev_reg[i] & pin_s2_reg[i];
        default:
          pin_event[i] = pin_prev_reg[i] ^ pin_s2_reg[i];
      endcase
      // Port input control gates detection; output drive plays no part
      pin_event[i] = pin_event[i] & pin_input_enable[i];
    end
  end

  // Source requests, ordered by vector number
  assign prio_all = {prio_hi_reg, prio_lo_reg};
  assign src_req = {periph_flag & periph_enable,
                    status_reg & enable_reg};
  assign routed = route_reg & XFER_ELIGIBLE;
  assign transfer_request = src_req & routed;
  // Routed sources reach the core only with the select bit set
  assign cand = src_req &
    ~(routed & {NUM_SRC{~transfer_interrupt_select}});

  // Transfer routing ignores levels and masks; only the core path is ranked
  // Scan from the top so a lower index wins every tie
  always_comb begin
    found    = 1'b0;
    best_idx = 5'h0;
    best_lvl = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (cand[i]) begin
        if (mode_reg == MODE_2) begin
          if (!found || prio_all[3*i +: 3] >= best_lvl) begin
            found    = 1'b1;
            best_idx = 5'(i);
            best_lvl = prio_all[3*i +: 3];
          end
        end else begin
          found    = 1'b1;
          best_idx = 5'(i);
          best_lvl = 3'h0;
        end
      end
    end
  end

  always_comb begin
    if (mode_reg == MODE_2) begin
      allowed = best_lvl > core_state.mask_level;
    end else begin
      allowed = ~core_state.mask_bit;
    end
  end

  assign sel_vec  = src_vector(best_idx);
  // Acceptance waits for the instruction boundary
  assign take_nmi = nmi_pend_reg & core_state.instr_done;
  assign take_src = ~nmi_pend_reg & found & allowed &
                    core_state.instr_done;
  // Nonmaskable pending always outranks a pin or peripheral
  // and is never gated by mode or mask
  assign core_request = nmi_pend_reg | (found & allowed);

  // Only bits read as 1 may be cleared, so a flag set after the read
  // survives the write of 0 that follows it
  assign wr_status = wr_en && addr == ADDR_STATUS;
  assign rd_status = rd_en && addr == ADDR_STATUS;

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_clear[i] = 1'b0;
      if (wr_status && !wdata[i] && seen_one_reg[i]) begin
        pin_clear[i] = 1'b1;
      end
      // A low level still held keeps the flag up after handling
      if (take_src && best_idx == 5'(i) &&
          (sense_reg[2*i +: 2] != SENSE_LOW || pin_s2_reg[i])) begin
        pin_clear[i] = 1'b1;
      end
      if (transfer_done[i] && !transfer_interrupt_select) begin
        pin_clear[i] = 1'b1;
      end
    end
  end

  // Register file and flags
  always_comb begin
    mode_next         = mode_reg;
    nmi_edge_sel_next = nmi_edge_sel_reg;
    sense_next        = sense_reg;
    enable_next       = enable_reg;
    prio_lo_next      = prio_lo_reg;
    prio_hi_next      = prio_hi_reg;
    route_next        = route_reg;
    last_vec_next     = last_vec_reg;
    rdata_next        = 32'h0;
    // A fresh event wins over any clear in the same cycle
    status_next   = pin_event | (status_reg & ~pin_clear);
    seen_one_next = seen_one_reg;
    if (rd_status) begin
      seen_one_next = status_reg;
    end else if (wr_status) begin
      seen_one_next = 15'h0;
    end
    if (wr_en) begin
      if (addr == ADDR_CTRL) begin
        // Only modes 0 and 2 exist; other codes are ignored
        if (wdata[CTRL_MODE_LSB +: 2] == MODE_0 ||
            wdata[CTRL_MODE_LSB +: 2] == MODE_2) begin
          mode_next = wdata[CTRL_MODE_LSB +: 2];
        end
        nmi_edge_sel_next = wdata[CTRL_NMI_EDGE_BIT];
      end else if (addr == ADDR_SENSE) begin
        sense_next = wdata[29:0];
      end else if (addr == ADDR_ENABLE) begin
        enable_next = wdata[14:0];
      end else if (addr == ADDR_PRIO_L) begin
        prio_lo_next = wdata[29:0];
      end else if (addr == ADDR_PRIO_H) begin
        prio_hi_next = wdata[26:0];
      end else if (addr == ADDR_ROUTE) begin
        route_next = wdata[18:0] & XFER_ELIGIBLE;
      end
    end
    if (rd_en) begin
      if (addr == ADDR_CTRL) begin
        rdata_next[CTRL_MODE_LSB +: 2]  = mode_reg;
        rdata_next[CTRL_NMI_EDGE_BIT]   = nmi_edge_sel_reg;
      end else if (addr == ADDR_SENSE) begin
        rdata_next[29:0] = sense_reg;
      end else if (addr == ADDR_ENABLE) begin
        rdata_next[14:0] = enable_reg;
      end else if (addr == ADDR_STATUS) begin
        rdata_next[14:0] = status_reg;
      end else if (addr == ADDR_PRIO_L) begin
        rdata_next[29:0] = prio_lo_reg;
      end else if (addr == ADDR_PRIO_H) begin
        rdata_next[26:0] = prio_hi_reg;
      end else if (addr == ADDR_ROUTE) begin
        rdata_next[18:0] = route_reg;
      end else if (addr == ADDR_LASTV) begin
        rdata_next[7:0] = last_vec_reg;
      end
    end
    if (take_nmi) begin
      last_vec_next = VEC_NMI;
    end else if (take_src) begin
      last_vec_next = sel_vec;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_reg         <= MODE_RST;
      nmi_edge_sel_reg <= NMIE_RST;
      sense_reg        <= SENSE_RST;
      enable_reg       <= EN_RST;
      status_reg       <= EN_RST;
      seen_one_reg     <= EN_RST;
      prio_lo_reg      <= PRL_RST;
      prio_hi_reg      <= PRH_RST;
      route_reg        <= ROUTE_RST;
      last_vec_reg     <= 8'h0;
      rdata_reg        <= 32'h0;
    end else begin
      mode_reg         <= mode_next;
      nmi_edge_sel_reg <= nmi_edge_sel_next;
      sense_reg        <= sense_next;
      enable_reg       <= enable_next;
      status_reg       <= status_next;
      seen_one_reg     <= seen_one_next;
      prio_lo_reg      <= prio_lo_next;
      prio_hi_reg      <= prio_hi_next;
      route_reg        <= route_next;
      last_vec_reg     <= last_vec_next;
      rdata_reg        <= rdata_next;
    end
  end

  // Core acceptance, error pulses and wake
  always_comb begin
    // Set wins over the acceptance clear
    nmi_pend_next = nmi_event | (nmi_pend_reg & ~take_nmi);
    accept_next   = '0;
    if (take_nmi) begin
      accept_next.take         = 1'b1;
      accept_next.vector       = VEC_NMI;
      accept_next.vaddr        = {6'h00, VEC_NMI, 2'h0};
      accept_next.mask_level   = NMI_LEVEL;
      accept_next.set_mask_bit = mode_reg == MODE_0;
      accept_next.clear_trace  = mode_reg == MODE_2;
    end else if (take_src) begin
      accept_next.take         = 1'b1;
      accept_next.vector       = sel_vec;
      accept_next.vaddr        = {6'h00, sel_vec, 2'h0};
      accept_next.mask_level   = best_lvl;
      accept_next.set_mask_bit = mode_reg == MODE_0;
      accept_next.clear_trace  = mode_reg == MODE_2;
    end
    err_next.transfer_error_set        = nmi_event;
    err_next.dma_error_flag_set        = nmi_event;
    err_next.dma_transfer_enable_clear = nmi_event;
    // Wake ignores the enables so a disabled pin can still release standby
    wake_next = nmi_event | (|pin_event);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nmi_pend_reg <= 1'b0;
      accept_reg   <= '0;
      err_reg      <= '0;
      wake_reg     <= 1'b0;
    end else begin
      nmi_pend_reg <= nmi_pend_next;
      accept_reg   <= accept_next;
      err_reg      <= err_next;
      wake_reg     <= wake_next;
    end
  end

  assign rdata        = rdata_reg;
  assign core_accept  = accept_reg;
  assign nmi_error    = err_reg;
  assign wake_request = wake_reg;
endmodule
`default_nettype wire

// ---- sim/intc_checker_asserts.sv ----
// Port assertions for the interrupt priority controller
`timescale 1ns/1ps
`default_nettype none
module intc_checker (
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   rd_en,
  input wire logic [31:0]            rdata,
  input wire logic                   core_request,
  input wire intc_pkg::core_state_t  core_state,
  input wire intc_pkg::core_accept_t core_accept,
  input wire intc_pkg::nmi_error_t   nmi_error
);
  import intc_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence accepted;
    core_accept.take;
  endsequence
  sequence nmi_hit;
    nmi_error.transfer_error_set;
  endsequence
  chk_take_cause:
    assert property (accepted |-> $past(core_request && core_state.instr_done))
    else $error("accept without request at a boundary");
  chk_vector_addr:
    assert property (accepted |->
      core_accept.vaddr == {6'h0, core_accept.vector, 2'h0})
    else $error("vector address is not four times vector");
  chk_idle_quiet:
    assert property (!core_accept.take |-> core_accept == '0)
    else $error("accept fields set without take");
  chk_nmi_group:
    assert property (nmi_hit |-> nmi_error == 3'h7 ##1 nmi_error == 3'h0)
    else $error("error pulses not one cycle together");
  chk_nmi_level:
    assert property (accepted and core_accept.clear_trace
      && core_accept.vector == VEC_NMI |-> core_accept.mask_level == NMI_LEVEL)
    else $error("nonmaskable accept does not load level 7");
  chk_one_mode:
    assert property (accepted |->
      core_accept.set_mask_bit != core_accept.clear_trace)
    else $error("accept carries both or neither mode action");
  chk_mask_bit:
    assert property (accepted and core_accept.set_mask_bit
      && $past(core_state.mask_bit) |-> core_accept.vector == VEC_NMI)
    else $error("masked source accepted in mode 0");
  chk_above_mask:
    assert property (accepted and core_accept.clear_trace
      && core_accept.vector != VEC_NMI |->
      core_accept.mask_level > $past(core_state.mask_level))
    else $error("accepted level not above mask level");
  chk_rdata_idle:
    assert property (!$past(rd_en) |-> rdata == '0)
    else $error("read data outside its cycle");
endmodule
bind interrupt_priority_controller intc_checker u_chk (
  .clock, .rst_n, .rd_en, .rdata, .core_request,
  .core_state, .core_accept, .nmi_error
);
`default_nettype wire

// ---- sim/core_model.sv ----
// Behavioural core that takes interrupts and tracks its mask state
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   boundary,
  input  wire logic                   restore,
  input  wire logic [2:0]             restore_level,
  input  wire intc_pkg::core_accept_t accept,
  output var  intc_pkg::core_state_t  state
);
  import intc_pkg::*;
  logic [2:0] busy_reg;
  logic       bit_reg;
  logic [2:0] lvl_reg;
  // Stacking keeps the core off boundaries, so a stale mask is never used
  assign state = '{boundary && busy_reg == 3'h0 && !accept.take,
                   bit_reg,
                   lvl_reg};
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_reg <= 3'h0;
      bit_reg  <= 1'b0;
      lvl_reg  <= 3'h0;
    end else if (accept.take) begin
      busy_reg <= 3'h6;
      if (accept.set_mask_bit) begin
        bit_reg <= 1'b1;
      end
      if (accept.clear_trace) begin
        lvl_reg <= accept.mask_level;
      end
    end else begin
      if (busy_reg != 3'h0) begin
        busy_reg <= busy_reg - 3'h1;
      end
      if (restore) begin
        bit_reg <= 1'b0;
        lvl_reg <= restore_level;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/interrupt_priority_controller_tb.sv ----
// Self-checking bench for the interrupt priority controller
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_controller_tb;
  import intc_pkg::*;
  logic              clock;
  logic              rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_en;
  logic              rd_en;
  logic [DATA_W-1:0] rdata;
  logic              nmi_pin;
  logic [14:0]       ext_pin;
  logic [14:0]       pin_ie;
  logic [3:0]        pflag;
  logic [3:0]        pen;
  core_state_t       cstate;
  logic              core_request;
  core_accept_t      acc;
  logic              boundary;
  logic              restore;
  logic [2:0]        rlevel;
  logic              rd_d;
  logic [18:0]       xreq;
  logic [14:0]       xdone;
  logic              xsel;
  logic              wake;
  int                n_wake;
  int                w0;
  int                n_fail;
  int                samples_checked;
  int                cycles;
  int                i;
  logic [31:0]       seed;
  logic [31:0]       er;
  core_accept_t      ea;
  logic [31:0]       rq[$];
  core_accept_t      aq[$];
  interrupt_priority_controller dut (
    .clock, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .nmi_pin,
    .external_request_pin(ext_pin), .pin_input_enable(pin_ie),
    .periph_flag(pflag), .periph_enable(pen), .core_state(cstate),
    .core_request, .core_accept(acc), .nmi_error(),
    .transfer_request(xreq), .transfer_done(xdone),
    .transfer_interrupt_select(xsel), .wake_request(wake)
  );
  core_model u_core (
    .clock, .rst_n, .boundary, .restore, .restore_level(rlevel),
    .accept(acc), .state(cstate)
  );
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp_word(input string nm, input logic [31:0] e,
                          input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic cmp_accept(input core_accept_t e, input core_accept_t s);
    // Mode 0 leaves the level field open, so it is not judged there
    if (e.set_mask_bit === 1'b1) begin
      e.mask_level = s.mask_level;
    end
    cmp_word("accept", 32'(e), 32'(s));
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
  endtask
  task automatic take(input logic [7:0] v, input logic [2:0] l,
                      input logic m2);
    aq.push_back('{1'b1, v, 16'(v) * 16'h4, l, !m2, m2});
  endtask
  task automatic unmask(input logic [2:0] l);
    @(posedge clock);
    restore <= 1'b1;
    rlevel  <= l;
    @(posedge clock);
    restore <= 1'b0;
  endtask
  task automatic pins(input logic [14:0] v);
    @(posedge clock);
    ext_pin <= v;
    repeat (6) @(posedge clock);
  endtask
  // Quiet cycles after draining catch any accept that should have pended
  task automatic settle;
    for (int k = 0; k < 300 && aq.size() + rq.size() > 0; k++) begin
      @(posedge clock);
    end
    cmp_word("pending", 32'h0, 32'(aq.size() + rq.size()));
    aq.delete();
    rq.delete();
    repeat (20) @(posedge clock);
  endtask
  always @(posedge clock) begin
    boundary <= 1'($random(seed));
  end
  always @(posedge clock) begin
    rd_d <= rd_en;
    cycles <= cycles + 1;
    if (rd_d) begin
      er = 'x;
      if (rq.size() > 0) begin
        er = rq.pop_front();
      end
      cmp_word("rdata", er, rdata);
    end
    if (acc.take === 1'b1) begin
      ea = 'x;
      if (aq.size() > 0) begin
        ea = aq.pop_front();
      end
      cmp_accept(ea, acc);
    end
    if (wake === 1'b1) begin
      n_wake <= n_wake + 1;
    end
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    seed = 32'h0cad0455;
    {rst_n, wr_en, rd_en, nmi_pin, restore, boundary, rd_d} = '0;
    addr = '0;
    wdata = '0;
    rlevel = '0;
    ext_pin = 15'h7fff;
    pin_ie = 15'h7fff;
    pflag = '0;
    pen = '0;
    xdone = '0;
    xsel = 1'b1;
    n_wake = 0;
    w0 = 0;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 9; i++) begin
      rd(4'(i), 32'h0);
    end
    wr(ADDR_SENSE, 32'h15555555);
    wr(ADDR_ENABLE, 32'h28);
    take(VEC_PIN0 + 8'h3, 3'h0, 1'b0);
    w0 = n_wake;
    pins(15'h7fd7);
    cmp_word("wake", 32'(w0 + 1), 32'(n_wake));
    settle();
    rd(ADDR_STATUS, 32'h20);
    wr(ADDR_CTRL, 32'h8);
    take(VEC_NMI, 3'h0, 1'b0);
    nmi_pin <= 1'b1;
    settle();
    rd(ADDR_LASTV, 32'h7);
    take(VEC_PIN0 + 8'h5, 3'h0, 1'b0);
    unmask(3'h0);
    settle();
    unmask(3'h0);
    pflag <= 4'h1;
    repeat (20) @(posedge clock);
    take(VEC_WDT, 3'h0, 1'b0);
    pen <= 4'h1;
    settle();
    pflag <= 4'h0;
    pins(15'h7fff);
    wr(ADDR_PRIO_L, 32'h16b);
    wr(ADDR_CTRL, 32'h28);
    unmask(3'h4);
    wr(ADDR_ENABLE, 32'h7);
    take(VEC_PIN0 + 8'h1, 3'h5, 1'b1);
    pins(15'h7ff8);
    settle();
    take(VEC_PIN0 + 8'h2, 3'h5, 1'b1);
    unmask(3'h4);
    settle();
    take(VEC_PIN0, 3'h3, 1'b1);
    unmask(3'h2);
    settle();
    // Level-sensed pins held low through handling, released after it
    take(VEC_PIN0 + 8'h1, 3'h5, 1'b1);
    wr(ADDR_SENSE, 32'h0);
    settle();
    pins(15'h7fff);
    rd(ADDR_STATUS, 32'h7);
    wr(ADDR_STATUS, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    pins(15'h7fff);
    wr(ADDR_ENABLE, 32'h0);
    pin_ie <= 15'h7dff;
    w0 = n_wake;
    pins(15'h7dff);
    cmp_word("wake", 32'(w0), 32'(n_wake));
    rd(ADDR_STATUS, 32'h0);
    pins(15'h7fff);
    pin_ie <= 15'h7fff;
    for (i = 0; i < 4; i++) begin
      wr(ADDR_SENSE, 32'(i) << 18);
      pins(15'h7dff);
      rd(ADDR_STATUS, i == 2 ? 32'h0 : 32'h200);
      pins(15'h7fff);
      rd(ADDR_STATUS, 32'h200);
      wr(ADDR_STATUS, 32'h0);
      rd(ADDR_STATUS, 32'h0);
    end
    take(VEC_NMI, NMI_LEVEL, 1'b1);
    nmi_pin <= 1'b0;
    repeat (4) @(posedge clock);
    nmi_pin <= 1'b1;
    settle();
    wr(ADDR_ROUTE, 32'h7ffff);
    rd(ADDR_ROUTE, 32'h57fff);
    xsel <= 1'b0;
    wr(ADDR_ENABLE, 32'h200);
    pins(15'h7dff);
    cmp_word("xfer", 32'h200, 32'(xreq));
    xdone <= 15'h200;
    @(posedge clock);
    xdone <= 15'h0;
    rd(ADDR_STATUS, 32'h0);
    cmp_word("xfer", 32'h0, 32'(xreq));
    settle();
    end_sim();
  end
endmodule
`default_nettype wire
